//--- pin_select_pkg.sv
/*
 Package for the remappable input select block: register map, field layout,
 reset values, unlock keys and the carrier structs.
 Assumes an APB slave with 32-bit data at 100 MHz on core_clk.
*/
package pin_select_pkg;
    localparam int NUM_REGS = 8;
    localparam int NUM_SEL = 14;
    localparam int NUM_PINS = 26;
    localparam int SEL_W = 5;
    localparam logic [4:0] SEL_MAX_PIN = 5'h19;
    localparam logic [4:0] SEL_GROUND = 5'h1f;
    localparam logic [4:0] SEL_RESET = 5'h1f;
    // Byte offsets of the route registers, index order 0..7, then the control register
    localparam logic [7:0] OFF_EXT_INT2 = 8'h00;
    localparam logic [7:0] OFF_TMR32 = 8'h04;
    localparam logic [7:0] OFF_TMR54 = 8'h08;
    localparam logic [7:0] OFF_CAP21 = 8'h0c;
    localparam logic [7:0] OFF_CAP87 = 8'h10;
    localparam logic [7:0] OFF_FAULT_A = 8'h14;
    localparam logic [7:0] OFF_SER1 = 8'h18;
    localparam logic [7:0] OFF_SER2 = 8'h1c;
    localparam logic [7:0] OFF_OSC_CTRL = 8'h20;
    // Field positions
    localparam int LO_LSB = 0;
    localparam int HI_LSB = 8;
    localparam int LOCK_BIT = 6;
    localparam int ONE_WAY_BIT = 8;
    localparam int MISMATCH_BIT = 9;
    localparam logic [7:0] UNLOCK_KEY1 = 8'h46;
    localparam logic [7:0] UNLOCK_KEY2 = 8'h57;
    localparam logic LOCK_RESET = 1'b0;
    // Which registers carry an upper field (bit per register index)
    localparam logic [7:0] HAS_HI = 8'hde;

    typedef struct packed {
        logic [7:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;

    typedef enum logic [1:0] {
        KEY_IDLE,
        KEY_ONE,
        KEY_OPEN
    } key_state_t;
endpackage

//--- remappable_input_select.sv
/*
 Remappable input select: eight route registers of 5-bit fields steer pins
 onto fourteen peripheral inputs, guarded by a lock with an unlock sequence.
 Every peripheral input is a flop fed by a per-field pin multiplexer; codes
 above the highest pin tie the input to ground.
 Shadow copies of the fields are kept beside the live fields and any
 difference raises a sticky configuration mismatch reset request.
 Write strobes are decoded in the setup cycle, so a write lands on the
 setup edge and the access cycle only carries the answer.
 Assumes remappable pins come from outside the clock domain and are
 synchronised here; one_way_lock_cfg is a static configuration level.
 Assumes an APB master that holds each request until pready is seen; the
 answer always comes in the access cycle right after the setup cycle.
 Pins reach the peripheral inputs three clock edges after they change.
*/
// The implementer's own choices: the register addresses and the APB slave port.
module remappable_input_select (
    input wire logic core_clk, // System clock, 100 MHz
    input wire logic rst_n, // Synchronous reset, active low
    input wire pin_select_pkg::apb_req_t apbReq, // APB request
    output pin_select_pkg::apb_rsp_t apbRsp, // APB answer, registered
    input wire logic [25:0] remappable_pin, // Remappable pin levels
    input wire logic one_way_lock_cfg, // One-way lock configuration
    output logic external_irq_two, // External interrupt 2 input
    output logic [3:0] tmrClkIn, // Timer 2..5 external clocks
    output logic [3:0] captureIn, // Capture 1,2,7,8 inputs
    output logic compareFaultA, // Compare fault A input
    output logic [1:0] serialRx, // Serial 1,2 receive
    output logic [1:0] serialCts, // Serial 1,2 clear-to-send
    output logic pin_select_lock, // Lock state
    output logic cfgMismatchReset // Configuration mismatch reset request
);
    logic [25:0] pinMeta;
    logic [25:0] pinSync;
    logic [4:0] selLo [pin_select_pkg::NUM_REGS];
    logic [4:0] selHi [pin_select_pkg::NUM_REGS];
    logic [4:0] shadowLo [pin_select_pkg::NUM_REGS];
    logic [4:0] shadowHi [pin_select_pkg::NUM_REGS];
    logic [4:0] fieldSel [pin_select_pkg::NUM_SEL];
    logic routed [pin_select_pkg::NUM_SEL];
    wire logic [pin_select_pkg::NUM_SEL-1:0] fieldIsPin;
    pin_select_pkg::key_state_t keyState;
    pin_select_pkg::key_state_t next_keyState;
    logic setup;
    logic wrEn;
    logic rdEn;
    logic keyWr;
    logic [7:0] wrByte;
    logic [2:0] regIdx;
    logic regHit;
    logic oscHit;
    logic addrOk;
    logic [pin_select_pkg::NUM_REGS-1:0] regWr;
    wire logic [pin_select_pkg::NUM_REGS-1:0] regMismatch;
    logic mismatch;
    logic next_lock;
    logic [31:0] next_rdata;
    pin_select_pkg::apb_rsp_t next_rsp;

    // Decode: setup cycle answers next cycle, no wait state
    assign setup = apbReq.psel && !apbReq.penable;
    assign regIdx = apbReq.paddr[4:2];
    assign regHit = (apbReq.paddr[7:5] == 3'h0) && (apbReq.paddr[1:0] == 2'h0);
    assign oscHit = apbReq.paddr == pin_select_pkg::OFF_OSC_CTRL;
    assign wrEn = setup && apbReq.pwrite;
    assign rdEn = setup && !apbReq.pwrite;

    // Write byte and address class for the key and error logic
    assign keyWr = wrEn && oscHit;
    assign wrByte = apbReq.pwdata[7:0];
    assign addrOk = regHit || oscHit;

    // First synchroniser stage; only the second stage reads it
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pinMeta <= '0;
        end else begin
            pinMeta <= remappable_pin;
        end
    end

    // Second synchroniser stage feeds the multiplexers
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pinSync <= '0;
        end else begin
            pinSync <= pinMeta;
        end
    end

    // One write strobe per route register; writes are dropped while locked
    always_comb begin
        regWr = '0;
        if (wrEn && regHit && !pin_select_lock) begin
            regWr[regIdx] = 1'b1;
        end
    end

    // Route register storage and its shadow, one slice per register index
    for (genvar r = 0; r < pin_select_pkg::NUM_REGS; r++) begin : g_reg
        // Lower field, present in every register
        always_ff @(posedge core_clk) begin
            if (!rst_n) begin
                selLo[r] <= pin_select_pkg::SEL_RESET;
            end else if (regWr[r]) begin
                selLo[r] <= apbReq.pwdata[pin_select_pkg::LO_LSB +: 5];
            end
        end

        // Upper field; registers without one keep it at the reset code
        always_ff @(posedge core_clk) begin
            if (!rst_n) begin
                selHi[r] <= pin_select_pkg::SEL_RESET;
            end else if (regWr[r] && pin_select_pkg::HAS_HI[r]) begin
                selHi[r] <= apbReq.pwdata[pin_select_pkg::HI_LSB +: 5];
            end
        end

        // Shadow of the lower field, loaded by the same legal write
        always_ff @(posedge core_clk) begin
            if (!rst_n) begin
                shadowLo[r] <= pin_select_pkg::SEL_RESET;
            end else if (regWr[r]) begin
                shadowLo[r] <= apbReq.pwdata[pin_select_pkg::LO_LSB +: 5];
            end
        end

        // Shadow of the upper field
        always_ff @(posedge core_clk) begin
            if (!rst_n) begin
                shadowHi[r] <= pin_select_pkg::SEL_RESET;
            end else if (regWr[r] && pin_select_pkg::HAS_HI[r]) begin
                shadowHi[r] <= apbReq.pwdata[pin_select_pkg::HI_LSB +: 5];
            end
        end

        // A live field that differs from its shadow was disturbed
        assign regMismatch[r] = (selLo[r] != shadowLo[r]) || (selHi[r] != shadowHi[r]);
    end

    // Any disturbed register raises the request
    assign mismatch = |regMismatch;

    // Sticky mismatch reset request, cleared only by reset
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cfgMismatchReset <= 1'b0;
        end else if (mismatch) begin
            cfgMismatchReset <= 1'b1;
        end
    end

    // Next key state: the keys count only as writes to the control low byte
    always_comb begin
        next_keyState = keyState;
        if (keyWr) begin
            unique case (keyState)
                pin_select_pkg::KEY_IDLE: begin
                    if (wrByte == pin_select_pkg::UNLOCK_KEY1) begin
                        next_keyState = pin_select_pkg::KEY_ONE;
                    end else begin
                        next_keyState = pin_select_pkg::KEY_IDLE;
                    end
                end
                pin_select_pkg::KEY_ONE: begin
                    if (wrByte == pin_select_pkg::UNLOCK_KEY2) begin
                        next_keyState = pin_select_pkg::KEY_OPEN;
                    end else if (wrByte == pin_select_pkg::UNLOCK_KEY1) begin
                        next_keyState = pin_select_pkg::KEY_ONE;
                    end else begin
                        next_keyState = pin_select_pkg::KEY_IDLE;
                    end
                end
                pin_select_pkg::KEY_OPEN: begin
                    if (wrByte == pin_select_pkg::UNLOCK_KEY1) begin
                        next_keyState = pin_select_pkg::KEY_ONE;
                    end else begin
                        next_keyState = pin_select_pkg::KEY_IDLE;
                    end
                end
                default: begin
                    next_keyState = pin_select_pkg::KEY_IDLE;
                end
            endcase
        end else if (wrEn) begin
            next_keyState = pin_select_pkg::KEY_IDLE; // Any other write breaks the sequence
        end
    end

    // Key state register
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            keyState <= pin_select_pkg::KEY_IDLE;
        end else begin
            keyState <= next_keyState;
        end
    end

    // Next lock: only the write right after the keys may change it
    always_comb begin
        next_lock = pin_select_lock;
        if (keyWr && keyState == pin_select_pkg::KEY_OPEN) begin
            if (apbReq.pwdata[pin_select_pkg::LOCK_BIT]) begin
                next_lock = 1'b1;
            end else if (one_way_lock_cfg && pin_select_lock) begin
                next_lock = 1'b1;
            end else begin
                next_lock = 1'b0;
            end
        end
    end

    // Lock register
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pin_select_lock <= pin_select_pkg::LOCK_RESET;
        end else begin
            pin_select_lock <= next_lock;
        end
    end

    // Field table: index to register and half
    always_comb begin
        fieldSel[0] = selLo[0];
        fieldSel[1] = selLo[1];
        fieldSel[2] = selHi[1];
        fieldSel[3] = selLo[2];
        fieldSel[4] = selHi[2];
        fieldSel[5] = selLo[3];
        fieldSel[6] = selHi[3];
        fieldSel[7] = selLo[4];
        fieldSel[8] = selHi[4];
        fieldSel[9] = selLo[5];
        fieldSel[10] = selLo[6];
        fieldSel[11] = selHi[6];
        fieldSel[12] = selLo[7];
        fieldSel[13] = selHi[7];
    end

    // One mux per peripheral input
    for (genvar f = 0; f < pin_select_pkg::NUM_SEL; f++) begin : g_mux
        // Codes up to the highest pin select a pin, the rest ground
        assign fieldIsPin[f] = fieldSel[f] <= pin_select_pkg::SEL_MAX_PIN;

        // Mux flop
        always_ff @(posedge core_clk) begin
            if (!rst_n) begin
                routed[f] <= 1'b0;
            end else if (fieldIsPin[f]) begin
                routed[f] <= pinSync[fieldSel[f]];
            end else begin
                routed[f] <= 1'b0;
            end
        end
    end

    // External interrupt 2 and compare fault A, single-field registers
    assign external_irq_two = routed[0];
    assign compareFaultA = routed[9];

    // Timer external clocks, timer 2 in bit 0 up to timer 5 in bit 3
    assign tmrClkIn[0] = routed[1];
    assign tmrClkIn[1] = routed[2];
    assign tmrClkIn[2] = routed[3];
    assign tmrClkIn[3] = routed[4];

    // Capture inputs 1, 2, 7 and 8 in that bit order
    assign captureIn[0] = routed[5];
    assign captureIn[1] = routed[6];
    assign captureIn[2] = routed[7];
    assign captureIn[3] = routed[8];

    // Serial receive inputs, serial 1 in bit 0
    assign serialRx[0] = routed[10];
    assign serialRx[1] = routed[12];

    // Serial clear-to-send inputs, serial 1 in bit 0
    assign serialCts[0] = routed[11];
    assign serialCts[1] = routed[13];

    // Read data by address; bits without a field read zero
    always_comb begin
        next_rdata = '0;
        unique case (apbReq.paddr)
            pin_select_pkg::OFF_EXT_INT2: begin
                next_rdata[pin_select_pkg::LO_LSB +: 5] = selLo[0];
            end
            pin_select_pkg::OFF_TMR32: begin
                next_rdata[pin_select_pkg::HI_LSB +: 5] = selHi[1];
                next_rdata[pin_select_pkg::LO_LSB +: 5] = selLo[1];
            end
            pin_select_pkg::OFF_TMR54: begin
                next_rdata[pin_select_pkg::HI_LSB +: 5] = selHi[2];
                next_rdata[pin_select_pkg::LO_LSB +: 5] = selLo[2];
            end
            pin_select_pkg::OFF_CAP21: begin
                next_rdata[pin_select_pkg::HI_LSB +: 5] = selHi[3];
                next_rdata[pin_select_pkg::LO_LSB +: 5] = selLo[3];
            end
            pin_select_pkg::OFF_CAP87: begin
                next_rdata[pin_select_pkg::HI_LSB +: 5] = selHi[4];
                next_rdata[pin_select_pkg::LO_LSB +: 5] = selLo[4];
            end
            pin_select_pkg::OFF_FAULT_A: begin
                next_rdata[pin_select_pkg::LO_LSB +: 5] = selLo[5];
            end
            pin_select_pkg::OFF_SER1: begin
                next_rdata[pin_select_pkg::HI_LSB +: 5] = selHi[6];
                next_rdata[pin_select_pkg::LO_LSB +: 5] = selLo[6];
            end
            pin_select_pkg::OFF_SER2: begin
                next_rdata[pin_select_pkg::HI_LSB +: 5] = selHi[7];
                next_rdata[pin_select_pkg::LO_LSB +: 5] = selLo[7];
            end
            pin_select_pkg::OFF_OSC_CTRL: begin
                next_rdata[pin_select_pkg::LOCK_BIT] = pin_select_lock;
                next_rdata[pin_select_pkg::ONE_WAY_BIT] = one_way_lock_cfg;
                next_rdata[pin_select_pkg::MISMATCH_BIT] = cfgMismatchReset;
            end
            default: begin
                next_rdata = '0;
            end
        endcase
    end

    // Answer contents for the access cycle that follows a setup
    always_comb begin
        next_rsp = '0;
        next_rsp.pready = setup;
        next_rsp.pslverr = setup && !addrOk;
        if (rdEn) begin
            next_rsp.prdata = next_rdata;
        end
    end

    // APB answer register: pready in the access cycle after each setup
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            apbRsp <= '0;
        end else begin
            apbRsp <= next_rsp;
        end
    end
endmodule

//--- remappable_input_select_monitor.sv
/* Port checker for remappable_input_select.
 Assumes it is bound onto the design top and sees only its ports. */
module remappable_input_select_monitor (
    input wire logic core_clk, // Clock
    input wire logic rst_n, // Reset, active low
    input wire pin_select_pkg::apb_req_t apbReq, // Request
    input wire pin_select_pkg::apb_rsp_t apbRsp, // Answer
    input wire logic one_way_lock_cfg, // One-way lock
    input wire logic external_irq_two, // Interrupt 2 input
    input wire logic compareFaultA, // Fault A input
    input wire logic pin_select_lock, // Lock state
    input wire logic cfgMismatchReset // Mismatch request
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // Bus phase decodes
    wire setup = apbReq.psel && !apbReq.penable;
    wire ctlWr = setup && apbReq.pwrite && apbReq.paddr == 8'h20;
    wire rdOk = apbRsp.pready && !apbRsp.pslverr && !apbReq.pwrite;
    a_ready_next: assert property (setup |=> apbRsp.pready && apbReq.penable)
        else $error("no answer after setup");
    a_rsvd_zero: assert property (rdOk && apbReq.paddr < 8'h20 |->
        apbRsp.prdata[31:13] == 19'h0 && apbRsp.prdata[7:5] == 3'h0) else $error("reserved bits set");
    a_single_field: assert property (rdOk && (apbReq.paddr == 8'h00 || apbReq.paddr == 8'h14) |->
        apbRsp.prdata[31:5] == 27'h0) else $error("upper field present");
    a_lock_keyed: assert property (!ctlWr |=> $stable(pin_select_lock))
        else $error("lock moved without write");
    a_keys_inert: assert property (ctlWr && apbReq.pwdata[7:0] == 8'h46 |=> $stable(pin_select_lock))
        else $error("key write moved lock");
    a_one_way_hold: assert property (one_way_lock_cfg && pin_select_lock |=> pin_select_lock)
        else $error("one-way lock cleared");
    a_reset_ground: assert property ($rose(rst_n) |-> !external_irq_two && !compareFaultA && !pin_select_lock)
        else $error("outputs not grounded after reset");
    a_no_mismatch: assert property (!cfgMismatchReset)
        else $error("mismatch reset raised");
endmodule

//--- tb_remappable_input_select.sv
/* Self-checking bench for remappable_input_select with a field model.
 Assumes one 100 MHz clock and an APB master driven here. */
module tb_remappable_input_select;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 0, rst_n = 0, one_way_lock_cfg = 0, err, mLock;
    pin_select_pkg::apb_req_t apbReq = '0;
    pin_select_pkg::apb_rsp_t apbRsp;
    logic [25:0] remappable_pin = '0;
    logic external_irq_two, compareFaultA, pin_select_lock, cfgMismatchReset;
    logic [3:0] tmrClkIn, captureIn;
    logic [1:0] serialRx, serialCts;
    logic [31:0] seed = 32'h83464996, rd;
    logic [4:0] m[8][2];
    int n_fail = 0, tests_run = 0, cyc = 0;
    remappable_input_select remappable_input_select_i (.core_clk, .rst_n, .apbReq, .apbRsp, .remappable_pin,
        .one_way_lock_cfg, .external_irq_two, .tmrClkIn, .captureIn, .compareFaultA, .serialRx, .serialCts,
        .pin_select_lock, .cfgMismatchReset);
    // Clock and hang guard
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_fail++;
            end_sim();
        end
    end
    function logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function logic rt(input logic [4:0] c);
        return c <= 5'd25 ? remappable_pin[c] : 1'b0;
    endfunction
    task check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // One APB transfer, held until pready is sampled
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk) apbReq <= '{a, 1'b1, 1'b0, w, d};
        @(posedge core_clk) apbReq.penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (apbRsp.pready !== 1'b1);
        rd = apbRsp.prdata;
        err = apbRsp.pslverr;
        apbReq.psel <= 1'b0;
        apbReq.penable <= 1'b0;
    endtask
    task rst_seq;
        @(posedge core_clk) rst_n <= 1'b0;
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        mLock = 0;
        for (int r = 0; r < 8; r++) begin
            m[r][0] = 5'h1f;
            m[r][1] = (r == 0 || r == 5) ? 5'h0 : 5'h1f;
        end
    endtask
    task wr(input int r, input logic [31:0] d);
        xfer(1'b1, 8'(r * 4), d);
        if (!mLock) begin
            m[r][0] = d[4:0];
            m[r][1] = (r == 0 || r == 5) ? 5'h0 : d[12:8];
        end
    endtask
    task rd_chk(input int r);
        xfer(1'b0, 8'(r * 4), 32'h0);
        check(rd, {19'h0, m[r][1], 3'h0, m[r][0]});
    endtask
    // Fresh random pins, then compare every routed input
    task out_chk;
        @(posedge core_clk) remappable_pin <= seed[25:0];
        seed = nxt(seed);
        repeat (4) @(posedge core_clk);
        check({serialCts[1], serialRx[1], serialCts[0], serialRx[0], compareFaultA, captureIn, tmrClkIn,
            external_irq_two}, {rt(m[7][1]), rt(m[7][0]), rt(m[6][1]), rt(m[6][0]), rt(m[5][0]), rt(m[4][1]),
            rt(m[4][0]), rt(m[3][1]), rt(m[3][0]), rt(m[2][1]), rt(m[2][0]), rt(m[1][1]), rt(m[1][0]),
            rt(m[0][0])});
    endtask
    task key(input logic v);
        xfer(1'b1, 8'h20, 32'h46);
        xfer(1'b1, 8'h20, 32'h57);
        xfer(1'b1, 8'h20, {25'h0, v, 6'h0});
    endtask
    // Main sequence
    initial begin
        rst_seq();
        for (int r = 0; r < 8; r++) rd_chk(r);
        out_chk();
        for (int c = 0; c < 32; c++) begin
            for (int r = 0; r < 8; r++) begin
                seed = nxt(seed);
                wr(r, {seed[31:13], 5'(31 - c), seed[7:5], c[4:0]});
                rd_chk(r);
            end
            out_chk();
        end
        $display("test route fields done");
        key(1'b1);
        check(pin_select_lock, 1);
        mLock = 1;
        wr(0, 32'h3);
        rd_chk(0);
        xfer(1'b1, 8'h20, 32'h46);
        wr(1, 32'h0);
        xfer(1'b1, 8'h20, 32'h57);
        xfer(1'b1, 8'h20, 32'h0);
        check(pin_select_lock, 1);
        key(1'b0);
        check(pin_select_lock, 0);
        mLock = 0;
        wr(0, 32'h4);
        rd_chk(0);
        one_way_lock_cfg <= 1'b1;
        key(1'b1);
        key(1'b0);
        check(pin_select_lock, 1);
        mLock = 1;
        wr(5, 32'h2);
        rd_chk(5);
        rst_seq();
        @(posedge core_clk);
        check(pin_select_lock, 0);
        rd_chk(0);
        $display("test lock done");
        xfer(1'b0, 8'h24, 32'h0);
        check(rd, 32'h0);
        check(err, 1);
        check(cfgMismatchReset, 0);
        $display("test unmapped done");
        end_sim();
    end
endmodule
bind remappable_input_select remappable_input_select_monitor mon_i (.core_clk, .rst_n, .apbReq, .apbRsp,
    .one_way_lock_cfg, .external_irq_two, .compareFaultA, .pin_select_lock, .cfgMismatchReset);
